// [hw/kwd_pkg.sv]
// Purpose: Shared constants and state types for the keyed guard timer.
// Assumes: 200 MHz system clock, classic Wishbone register access.
// Notes:   Offsets are byte addresses on a 32-bit data bus.
package kwd_pkg;

  // Register byte offsets
  localparam int unsigned ADR_W           = 12;
  localparam logic [11:0] OFS_CONFIG      = 12'h000;
  localparam logic [11:0] OFS_KICK        = 12'h004;
  localparam logic [11:0] OFS_LOCK        = 12'h008;
  localparam logic [11:0] OFS_COUNT       = 12'h00C;
  localparam logic [11:0] OFS_RG_CONFIG   = 12'h010;
  localparam logic [11:0] OFS_RG_STATUS   = 12'h014;
  localparam logic [11:0] OFS_IRQ_ENABLE  = 12'h200;
  localparam logic [11:0] OFS_IRQ_STATUS  = 12'h204;
  localparam logic [11:0] OFS_IRQ_CLEAR   = 12'h208;
  localparam logic [11:0] OFS_IRQ_FORCE   = 12'h20C;

  // Field positions of guard_config, reset-generator and interrupt registers
  localparam int unsigned CFG_RUN_BIT     = 0;
  localparam int unsigned CFG_WARN_BIT    = 1;
  localparam int unsigned CFG_EXPIRE_BIT  = 2;
  localparam int unsigned CFG_EXPCMP_LSB  = 8;
  localparam int unsigned CFG_WARNCMP_LSB = 16;
  localparam int unsigned CFG_RATE_LSB    = 24;
  localparam int unsigned RG_ENABLE_BIT   = 1;
  localparam int unsigned RG_CAUSE_BIT    = 6;
  localparam int unsigned IRQ_BIT         = 0;

  // Reset values and keys
  localparam logic [7:0]  CMP_RST         = 8'hFF;
  localparam logic [2:0]  RATE_RST        = 3'h0;
  localparam logic [7:0]  KICK_KEY        = 8'hB2;
  localparam logic [7:0]  LOCK_KEY        = 8'h3A;

  // Tick-rate select codes
  localparam logic [2:0]  RATE_OFF        = 3'h0;
  localparam logic [2:0]  RATE_128HZ      = 3'h1;
  localparam logic [2:0]  RATE_16HZ       = 3'h2;
  localparam logic [2:0]  RATE_1HZ        = 3'h3;
  localparam logic [2:0]  RATE_1_16HZ     = 3'h4;

  // Timing: base tick from the system clock, slower ticks by division
  localparam int unsigned CLK_FREQ_HZ     = 200_000_000;
  localparam int unsigned TICK_128HZ      = 128;
  localparam int unsigned TICK_16HZ       = 16;
  localparam int unsigned TICK_1HZ        = 1;
  localparam int unsigned TICK_SLOW_S     = 16;
  localparam int unsigned TICK_BASE_CYCLES = CLK_FREQ_HZ / TICK_128HZ;
  localparam logic [3:0]  DIV_16HZ_LAST   = 4'(TICK_128HZ / TICK_16HZ - 1);
  localparam logic [3:0]  DIV_1HZ_LAST    = 4'(TICK_16HZ / TICK_1HZ - 1);
  localparam logic [3:0]  DIV_SLOW_LAST   = 4'(TICK_SLOW_S * TICK_1HZ - 1);

  // State of the tick generator
  typedef struct packed {
    logic [31:0] base_cnt;
    logic [3:0]  div16_cnt;
    logic [3:0]  div1_cnt;
    logic [3:0]  slow_cnt;
    logic        tick;
  } kwd_tick_state_t;

  localparam kwd_tick_state_t TICK_STATE_RST = '{32'h0, 4'h0, 4'h0, 4'h0, 1'b0};

  // State of the guard timer top
  typedef struct packed {
    logic        run_en;
    logic        warn_en;
    logic        expire_en;
    logic [7:0]  expire_cmp;
    logic [7:0]  warn_cmp;
    logic [2:0]  rate;
    logic        locked;
    logic [7:0]  count;
    logic        irq_en;
    logic        irq_stat;
    logic        rg_enable;
    logic        cause;
    logic        ack;
    logic [31:0] rdata;
    logic        irq;
    logic        reset_req;
  } kwd_state_t;

  localparam kwd_state_t STATE_RST = '{1'b0, 1'b0, 1'b0, CMP_RST, CMP_RST, RATE_RST,
                                       1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                                       32'h0, 1'b0, 1'b0};

endpackage : kwd_pkg

// [hw/kwd_tick_gen.sv]
// Purpose: Divides the system clock into the selectable guard timer ticks.
// Assumes: Clock enable freezes the divider chain along with everything else.
// Notes:   Base period is a parameter so simulation can shorten it.
`timescale 1ns/10ps
`default_nettype none
module kwd_tick_gen #(
  parameter int unsigned BASE_CYCLES = kwd_pkg::TICK_BASE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic [2:0] rate_sel,
  output var  logic       tick
);

  kwd_pkg::kwd_tick_state_t q;
  kwd_pkg::kwd_tick_state_t d;
  logic                     evt_base;
  logic                     evt_16;
  logic                     evt_1;
  logic                     evt_slow;

  // Divider chain; chain keeps running while stopped so rate changes stay aligned
  always_comb begin
    d        = q;
    evt_base = (q.base_cnt == 32'(BASE_CYCLES - 1));
    evt_16   = evt_base && (q.div16_cnt == kwd_pkg::DIV_16HZ_LAST);
    evt_1    = evt_16 && (q.div1_cnt == kwd_pkg::DIV_1HZ_LAST);
    evt_slow = evt_1 && (q.slow_cnt == kwd_pkg::DIV_SLOW_LAST);
    d.base_cnt = evt_base ? 32'h0 : 32'(q.base_cnt + 32'h1);
    if (evt_base) begin
      d.div16_cnt = evt_16 ? 4'h0 : 4'(q.div16_cnt + 4'h1);
    end
    if (evt_16) begin
      d.div1_cnt = evt_1 ? 4'h0 : 4'(q.div1_cnt + 4'h1);
    end
    if (evt_1) begin
      d.slow_cnt = evt_slow ? 4'h0 : 4'(q.slow_cnt + 4'h1);
    end
    // Undefined codes give no tick, same as the stopped setting
    case (rate_sel)
      kwd_pkg::RATE_128HZ:  d.tick = evt_base;
      kwd_pkg::RATE_16HZ:   d.tick = evt_16;
      kwd_pkg::RATE_1HZ:    d.tick = evt_1;
      kwd_pkg::RATE_1_16HZ: d.tick = evt_slow;
      default:              d.tick = 1'b0;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= kwd_pkg::TICK_STATE_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign tick = q.tick;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_stop_no_tick;
    (ce && rate_sel == kwd_pkg::RATE_OFF) |=> !tick;
  endproperty
  a_stop_no_tick: assert property (p_stop_no_tick) else $error("tick while stopped");

endmodule : kwd_tick_gen
`default_nettype wire

// [hw/kwd_guard_timer.sv]
// Purpose: Keyed guard timer with early warning, expiry reset request and lock.
// Assumes: Classic Wishbone slave, one clock, nrst is the power-on reset.
// Notes:   Reset request is sticky until nrst; the system reset is expected to follow.
//
// Summary of operation
// - Request system reset when count reaches expiry compare before any restart.
// - Tick select 0 stops, 1..4 give 128, 16, 1, 1/16 Hz.
// - Warning compare, bits 23:16, reset 0xFF, matched against count.
// - Expiry compare, bits 15:8, reset 0xFF, matched against count.
// - Reset happens only with expiry enable and reset-generator enable both set.
// - Warning sets the status bit only while warning enable is set.
// - Config bit 0 runs the counter; cleared, nothing counts or fires.
// - Writing 0xB2 to the kick low byte restarts the count.
// - Writing 0x3A to lock forces run enable and blocks config writes.
// - Count register shows the counter in bits 7:0, upper zero.
// - Interrupt output is status bit 0 and enable bit 0 together.
// - Writing one to clear bit 0 clears status; zero does nothing.
// - Writing one to force bit 0 sets status at once.
// - Interrupt status register readable, status flag in bit 0.
// - Reset-generator config bit 1, reset zero, gates the expiry reset.
// - Reset-generator cause flag at status bit 6 records guard reset, read-only.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module kwd_guard_timer #(
  parameter int unsigned TICK_BASE_CYCLES = kwd_pkg::TICK_BASE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  output var  logic        irq_o,
  output var  logic        sys_reset_req_o
);

  kwd_pkg::kwd_state_t q;
  kwd_pkg::kwd_state_t d;
  logic                tick;
  logic                bus_req;
  logic                wr;
  logic                kick_hit;
  logic                lock_hit;
  logic                cfg_wr;
  logic                advance;
  logic [7:0]          count_inc;
  logic                warn_evt;
  logic                expire_evt;
  logic [31:0]         rd;

  // Exact address match, shared by read and write decoding
  function automatic logic hit(input logic [11:0] adr, input logic [11:0] ofs);
    hit = (adr == ofs);
  endfunction : hit

  // Key write: low byte lane must be selected and carry the key
  function automatic logic key_hit(input logic [11:0] adr, input logic [11:0] ofs,
                                   input logic sel0, input logic [7:0] dat,
                                   input logic [7:0] key);
    key_hit = hit(adr, ofs) && sel0 && (dat == key);
  endfunction : key_hit

  // Tick generator
  kwd_tick_gen #(
    .BASE_CYCLES (TICK_BASE_CYCLES)
  ) u_tick (
    .clk      (clk),
    .nrst     (nrst),
    .ce       (ce),
    .rate_sel (q.rate),
    .tick     (tick)
  );

  // Read mux; write-only and unmapped locations read as zero
  always_comb begin
    rd = 32'h0;
    if (hit(wb_adr_i, kwd_pkg::OFS_CONFIG)) begin
      rd[kwd_pkg::CFG_RUN_BIT]    = q.run_en;
      rd[kwd_pkg::CFG_WARN_BIT]   = q.warn_en;
      rd[kwd_pkg::CFG_EXPIRE_BIT] = q.expire_en;
      rd[kwd_pkg::CFG_EXPCMP_LSB +: 8]  = q.expire_cmp;
      rd[kwd_pkg::CFG_WARNCMP_LSB +: 8] = q.warn_cmp;
      rd[kwd_pkg::CFG_RATE_LSB +: 3]    = q.rate;
    end else if (hit(wb_adr_i, kwd_pkg::OFS_COUNT)) begin
      rd[7:0] = q.count;
    end else if (hit(wb_adr_i, kwd_pkg::OFS_RG_CONFIG)) begin
      rd[kwd_pkg::RG_ENABLE_BIT] = q.rg_enable;
    end else if (hit(wb_adr_i, kwd_pkg::OFS_RG_STATUS)) begin
      rd[kwd_pkg::RG_CAUSE_BIT] = q.cause;
    end else if (hit(wb_adr_i, kwd_pkg::OFS_IRQ_ENABLE)) begin
      rd[kwd_pkg::IRQ_BIT] = q.irq_en;
    end else if (hit(wb_adr_i, kwd_pkg::OFS_IRQ_STATUS)) begin
      rd[kwd_pkg::IRQ_BIT] = q.irq_stat;
    end else begin
      rd = 32'h0;
    end
  end

  // Next-state logic for bus, configuration, counter and flags
  always_comb begin
    d          = q;
    bus_req    = wb_cyc_i && wb_stb_i;
    // A write lands at the edge where the master sees ack high
    wr         = bus_req && wb_we_i && q.ack && ce;
    kick_hit   = wr && key_hit(wb_adr_i, kwd_pkg::OFS_KICK, wb_sel_i[0],
                               wb_dat_i[7:0], kwd_pkg::KICK_KEY);
    lock_hit   = wr && key_hit(wb_adr_i, kwd_pkg::OFS_LOCK, wb_sel_i[0],
                               wb_dat_i[7:0], kwd_pkg::LOCK_KEY);
    cfg_wr     = wr && hit(wb_adr_i, kwd_pkg::OFS_CONFIG) && !q.locked;
    advance    = q.run_en && tick && !kick_hit;
    count_inc  = 8'(q.count + 8'h01);
    // Compare on the step into the value, so each match fires once per lap
    warn_evt   = advance && (count_inc == q.warn_cmp);
    expire_evt = advance && (count_inc == q.expire_cmp);

    // Single-cycle ack, dropped the cycle after it is given
    d.ack   = bus_req && !q.ack;
    d.rdata = (bus_req && !q.ack && !wb_we_i) ? rd : 32'h0;

    // Configuration, byte lane by byte lane
    if (cfg_wr && wb_sel_i[0]) begin
      d.run_en    = wb_dat_i[kwd_pkg::CFG_RUN_BIT];
      d.warn_en   = wb_dat_i[kwd_pkg::CFG_WARN_BIT];
      d.expire_en = wb_dat_i[kwd_pkg::CFG_EXPIRE_BIT];
    end
    if (cfg_wr && wb_sel_i[1]) begin
      d.expire_cmp = wb_dat_i[kwd_pkg::CFG_EXPCMP_LSB +: 8];
    end
    if (cfg_wr && wb_sel_i[2]) begin
      d.warn_cmp = wb_dat_i[kwd_pkg::CFG_WARNCMP_LSB +: 8];
    end
    if (cfg_wr && wb_sel_i[3]) begin
      d.rate = wb_dat_i[kwd_pkg::CFG_RATE_LSB +: 3];
    end

    // Lock is one-way until power-on reset; software cannot undo it
    if (lock_hit) begin
      d.locked = 1'b1;
    end
    if (lock_hit || q.locked) begin
      d.run_en = 1'b1;
    end

    // Counter: kick wins over a tick in the same cycle
    if (kick_hit) begin
      d.count = 8'h00;
    end else if (advance) begin
      d.count = count_inc;
    end

    // Interrupt enable and reset-generator enable
    if (wr && wb_sel_i[0] && hit(wb_adr_i, kwd_pkg::OFS_IRQ_ENABLE)) begin
      d.irq_en = wb_dat_i[kwd_pkg::IRQ_BIT];
    end
    if (wr && wb_sel_i[0] && hit(wb_adr_i, kwd_pkg::OFS_RG_CONFIG)) begin
      d.rg_enable = wb_dat_i[kwd_pkg::RG_ENABLE_BIT];
    end

    // Status: clears first, sets last so a coincident event is kept
    if (wr && wb_sel_i[0] && hit(wb_adr_i, kwd_pkg::OFS_IRQ_STATUS)) begin
      d.irq_stat = wb_dat_i[kwd_pkg::IRQ_BIT];
    end
    if (wr && wb_sel_i[0] && hit(wb_adr_i, kwd_pkg::OFS_IRQ_CLEAR) &&
        wb_dat_i[kwd_pkg::IRQ_BIT]) begin
      d.irq_stat = 1'b0;
    end
    if (wr && wb_sel_i[0] && hit(wb_adr_i, kwd_pkg::OFS_IRQ_FORCE) &&
        wb_dat_i[kwd_pkg::IRQ_BIT]) begin
      d.irq_stat = 1'b1;
    end
    if (warn_evt && q.warn_en) begin
      d.irq_stat = 1'b1;
    end

    // Expiry: both enables needed; request and cause flag are sticky
    if (expire_evt && q.expire_en && q.rg_enable) begin
      d.reset_req = 1'b1;
      d.cause     = 1'b1;
    end

    // Registered interrupt, from the values about to be stored
    d.irq = d.irq_stat && d.irq_en;
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= kwd_pkg::STATE_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // Outputs, all straight from the state register
  assign wb_dat_o        = q.rdata;
  assign wb_ack_o        = q.ack;
  assign irq_o           = q.irq;
  assign sys_reset_req_o = q.reset_req;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_kick_taken;
    kick_hit;
  endsequence

  sequence s_count_zero_next;
    ##1 (q.count == 8'h00);
  endsequence

  property p_kick_restarts;
    s_kick_taken |-> s_count_zero_next;
  endproperty
  a_kick_restarts: assert property (p_kick_restarts) else $error("kick did not zero count");

  property p_bad_key_ignored;
    (wr && hit(wb_adr_i, kwd_pkg::OFS_KICK) && wb_dat_i[7:0] != kwd_pkg::KICK_KEY
     && !advance) |=> $stable(q.count);
  endproperty
  a_bad_key_ignored: assert property (p_bad_key_ignored) else $error("wrong key moved count");

  property p_locked_cfg_frozen;
    (q.locked && ce) |=> ($stable(q.warn_cmp) && $stable(q.expire_cmp) && $stable(q.rate)
                          && q.run_en);
  endproperty
  a_locked_cfg_frozen: assert property (p_locked_cfg_frozen) else $error("locked config changed");

  property p_disabled_no_count;
    (ce && !q.run_en && !kick_hit) |=> $stable(q.count) && !$rose(q.reset_req);
  endproperty
  a_disabled_no_count: assert property (p_disabled_no_count) else $error("counted while disabled");

  property p_count_step;
    (ce && advance) |=> (q.count == 8'($past(q.count) + 8'h01));
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step by one");

  property p_irq_output;
    irq_o == (q.irq_stat && q.irq_en);
  endproperty
  a_irq_output: assert property (p_irq_output) else $error("irq output mismatch");

  property p_warn_sets_status;
    (ce && warn_evt && q.warn_en) |=> q.irq_stat;
  endproperty
  a_warn_sets_status: assert property (p_warn_sets_status) else $error("warning lost");

  property p_warn_gated;
    (ce && warn_evt && !q.warn_en && !wr && !q.irq_stat) |=> !q.irq_stat;
  endproperty
  a_warn_gated: assert property (p_warn_gated) else $error("warning set status while off");

  property p_reset_gated;
    $rose(sys_reset_req_o) |-> $past(q.expire_en && q.rg_enable && expire_evt) && q.cause;
  endproperty
  a_reset_gated: assert property (p_reset_gated) else $error("reset without both enables");

  property p_expiry_resets;
    (ce && expire_evt && q.expire_en && q.rg_enable) |=> sys_reset_req_o ##1 sys_reset_req_o;
  endproperty
  a_expiry_resets: assert property (p_expiry_resets) else $error("expiry gave no reset");

  property p_clear_status;
    (wr && wb_sel_i[0] && hit(wb_adr_i, kwd_pkg::OFS_IRQ_CLEAR) && wb_dat_i[0]
     && !warn_evt) |=> !q.irq_stat;
  endproperty
  a_clear_status: assert property (p_clear_status) else $error("clear did not clear");

  property p_force_status;
    (wr && wb_sel_i[0] && hit(wb_adr_i, kwd_pkg::OFS_IRQ_FORCE) && wb_dat_i[0])
      |=> q.irq_stat;
  endproperty
  a_force_status: assert property (p_force_status) else $error("force did not set");

  // Clock enable low stretches ack, so only a running cycle must drop it
  property p_ack_single;
    (wb_ack_o && ce) |=> !wb_ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");

  property p_ack_answer;
    (ce && bus_req && !q.ack) |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acked");

  property p_idle_data_zero;
    !wb_ack_o |-> (wb_dat_o == 32'h0);
  endproperty
  a_idle_data_zero: assert property (p_idle_data_zero) else $error("data outside ack");

  property p_count_read;
    (ce && bus_req && !q.ack && !wb_we_i && hit(wb_adr_i, kwd_pkg::OFS_COUNT))
      |=> (wb_dat_o == {24'h0, $past(q.count)});
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read wrong");

  property p_status_read;
    (ce && bus_req && !q.ack && !wb_we_i && hit(wb_adr_i, kwd_pkg::OFS_IRQ_STATUS))
      |=> (wb_dat_o == {31'h0, $past(q.irq_stat)});
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_cause_read;
    (ce && bus_req && !q.ack && !wb_we_i && hit(wb_adr_i, kwd_pkg::OFS_RG_STATUS))
      |=> (wb_dat_o == {25'h0, $past(q.cause), 6'h00});
  endproperty
  a_cause_read: assert property (p_cause_read) else $error("cause read wrong");

  property p_warn_cmp_write;
    (cfg_wr && wb_sel_i[2]) |=> (q.warn_cmp == $past(wb_dat_i[kwd_pkg::CFG_WARNCMP_LSB +: 8]));
  endproperty
  a_warn_cmp_write: assert property (p_warn_cmp_write) else $error("warn compare lost");

  property p_exp_cmp_write;
    (cfg_wr && wb_sel_i[1]) |=> (q.expire_cmp == $past(wb_dat_i[kwd_pkg::CFG_EXPCMP_LSB +: 8]));
  endproperty
  a_exp_cmp_write: assert property (p_exp_cmp_write) else $error("expiry compare lost");

  property p_rate_write;
    (cfg_wr && wb_sel_i[3]) |=> (q.rate == $past(wb_dat_i[kwd_pkg::CFG_RATE_LSB +: 3]));
  endproperty
  a_rate_write: assert property (p_rate_write) else $error("rate select lost");

  property p_lock_sticky;
    q.locked |=> (q.locked && q.run_en);
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock released");

  property p_reset_sticky;
    sys_reset_req_o |=> (sys_reset_req_o && q.cause);
  endproperty
  a_reset_sticky: assert property (p_reset_sticky) else $error("reset request dropped");

  property p_gate_closed;
    (ce && expire_evt && !q.rg_enable && !sys_reset_req_o) |=> !sys_reset_req_o;
  endproperty
  a_gate_closed: assert property (p_gate_closed) else $error("reset with gate shut");

  property p_no_tick_hold;
    (ce && !tick && !kick_hit) |=> $stable(q.count);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold) else $error("count moved without tick");

endmodule : kwd_guard_timer
`default_nettype wire

// [bench/kwd_guard_timer_tb.sv]
// Purpose: Self-checking bench for the keyed guard timer over classic Wishbone.
// Assumes: Base tick shortened to 4 cycles; ce dropped once to check the freeze.
// Notes:   Each access queues its expected read range; the ack monitor compares.
`timescale 1ns/10ps
`default_nettype none
module kwd_guard_timer_tb;
  localparam int unsigned BASE = 4;
  typedef struct packed {
    logic        rd;
    logic [31:0] lo;
    logic [31:0] hi;
  } kwd_exp_t;

  logic        clk;
  logic        nrst;
  logic        ce;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_o;
  logic        sys_reset_req_o;
  int          mismatches;
  int          checks;
  int          seed;
  int          i;
  logic [31:0] v;
  kwd_exp_t    mon_e;
  kwd_exp_t    exp_q[$];
  int          per [4]   = '{BASE, BASE * 8, BASE * 128, BASE * 2048};
  logic [11:0] rst_adr [9] = '{kwd_pkg::OFS_CONFIG, kwd_pkg::OFS_KICK, kwd_pkg::OFS_LOCK,
                              kwd_pkg::OFS_COUNT, kwd_pkg::OFS_RG_CONFIG,
                              kwd_pkg::OFS_RG_STATUS, kwd_pkg::OFS_IRQ_ENABLE,
                              kwd_pkg::OFS_IRQ_STATUS, 12'h100};

  kwd_guard_timer #(
    .TICK_BASE_CYCLES (BASE)
  ) kwd_guard_timer_inst (
    .clk             (clk),
    .nrst            (nrst),
    .ce              (ce),
    .wb_cyc_i        (wb_cyc_i),
    .wb_stb_i        (wb_stb_i),
    .wb_we_i         (wb_we_i),
    .wb_adr_i        (wb_adr_i),
    .wb_sel_i        (wb_sel_i),
    .wb_dat_i        (wb_dat_i),
    .wb_dat_o        (wb_dat_o),
    .wb_ack_o        (wb_ack_o),
    .irq_o           (irq_o),
    .sys_reset_req_o (sys_reset_req_o)
  );

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // Config word from its fields
  function automatic logic [31:0] cfg(input logic [2:0] r, input logic [7:0] w,
                                      input logic [7:0] e, input logic [2:0] en);
    return {5'h00, r, w, e, 5'h00, en};
  endfunction : cfg

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [11:0] adr, input logic [3:0] sel,
                    input logic [31:0] dat, input logic [31:0] lo, input logic [31:0] hi);
    int n;
    @(posedge clk);
    exp_q.push_back(kwd_exp_t'{!we, lo, hi});
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      $display("[FAIL] %0t ns: no ack", $time);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, 4'hF, dat, 32'h0, 32'h0);
  endtask : wr

  task automatic rd(input logic [11:0] adr, input logic [31:0] lo, input logic [31:0] hi);
    wb(1'b0, adr, 4'hF, 32'h0, lo, hi);
  endtask : rd

  task automatic kick;
    wr(kwd_pkg::OFS_KICK, 32'h000000B2);
  endtask : kick

  // Ack monitor: oldest note against read data; range reads pass when inside
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      if (mon_e.rd && mon_e.lo == mon_e.hi) begin
        check(wb_dat_o, mon_e.lo);
      end else if (mon_e.rd) begin
        check({31'h0, (wb_dat_o >= mon_e.lo && wb_dat_o <= mon_e.hi)}, 32'h1);
      end else begin
        check(wb_dat_o, 32'h0);
      end
    end
  end

  // Watchdog against a hung run; the tests need about 27k cycles
  initial begin
    #400000;
    mismatches++;
    $display("[FAIL] %0t ns: run did not finish", $time);
    report_and_stop();
  end

  initial begin
    clk = 1'b0; nrst = 1'b0; ce = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
    wb_adr_i = 12'h000; wb_sel_i = 4'h0; wb_dat_i = 32'h0;
    mismatches = 0; checks = 0; seed = 22351;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    // Reset values, write-only places and an unmapped hole all read as documented
    wr(12'h100, 32'hFFFFFFFF);
    for (i = 0; i < 9; i++) begin
      v = (i == 0) ? 32'h00FFFF00 : 32'h0;
      rd(rst_adr[i], v, v);
    end
    // Random config words: only defined fields stick
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(kwd_pkg::OFS_CONFIG, v);
      rd(kwd_pkg::OFS_CONFIG, v & 32'h07FFFF07, v & 32'h07FFFF07);
    end
    wr(kwd_pkg::OFS_IRQ_CLEAR, 32'h1);
    // Stopped rate holds count; count register ignores writes
    wr(kwd_pkg::OFS_CONFIG, cfg(3'h0, 8'hFF, 8'hFF, 3'h1));
    kick();
    wr(kwd_pkg::OFS_COUNT, 32'hFFFFFFFF);
    repeat (40) @(posedge clk);
    rd(kwd_pkg::OFS_COUNT, 32'h0, 32'h0);
    // Run bit clear: ticking rate but no counting
    wr(kwd_pkg::OFS_CONFIG, cfg(3'h1, 8'hFF, 8'hFF, 3'h0));
    repeat (40) @(posedge clk);
    rd(kwd_pkg::OFS_COUNT, 32'h0, 32'h0);
    // Each rate code: three periods give three or four ticks
    for (i = 0; i < 4; i++) begin
      wr(kwd_pkg::OFS_CONFIG, cfg(3'(i + 1), 8'hFF, 8'hFF, 3'h1));
      kick();
      repeat (3 * per[i]) @(posedge clk);
      rd(kwd_pkg::OFS_COUNT, 32'h3, 32'h4);
    end
    // Wrong key or missing lane leaves count alone; right key restarts it
    wr(kwd_pkg::OFS_CONFIG, cfg(3'h1, 8'hFF, 8'hFF, 3'h1));
    kick();
    repeat (40) @(posedge clk);
    wr(kwd_pkg::OFS_KICK, 32'h000000B3);
    wb(1'b1, kwd_pkg::OFS_KICK, 4'hE, 32'h000000B2, 32'h0, 32'h0);
    rd(kwd_pkg::OFS_COUNT, 32'hA, 32'h10);
    wr(kwd_pkg::OFS_KICK, 32'hFFFFFFB2);
    rd(kwd_pkg::OFS_COUNT, 32'h0, 32'h1);
    // Clock enable low freezes counter and divider; only five running edges pass
    @(posedge clk);
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    ce <= 1'b1;
    rd(kwd_pkg::OFS_COUNT, 32'h1, 32'h2);
    // Early warning reaches status and the interrupt line
    wr(kwd_pkg::OFS_IRQ_ENABLE, 32'h1);
    wr(kwd_pkg::OFS_CONFIG, cfg(3'h1, 8'h03, 8'hFF, 3'h3));
    kick();
    repeat (20) @(posedge clk);
    check({31'h0, irq_o}, 32'h1);
    rd(kwd_pkg::OFS_IRQ_STATUS, 32'h1, 32'h1);
    wr(kwd_pkg::OFS_IRQ_CLEAR, 32'h0);
    rd(kwd_pkg::OFS_IRQ_STATUS, 32'h1, 32'h1);
    wr(kwd_pkg::OFS_IRQ_CLEAR, 32'h1);
    rd(kwd_pkg::OFS_IRQ_STATUS, 32'h0, 32'h0);
    repeat (2) @(posedge clk);
    check({31'h0, irq_o}, 32'h0);
    // Force for test, then mask the line
    wr(kwd_pkg::OFS_IRQ_FORCE, 32'h1);
    rd(kwd_pkg::OFS_IRQ_STATUS, 32'h1, 32'h1);
    check({31'h0, irq_o}, 32'h1);
    wr(kwd_pkg::OFS_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge clk);
    check({31'h0, irq_o}, 32'h0);
    wr(kwd_pkg::OFS_IRQ_CLEAR, 32'h1);
    // Warning enable off: a match leaves status clear
    wr(kwd_pkg::OFS_CONFIG, cfg(3'h1, 8'h03, 8'hFF, 3'h1));
    kick();
    repeat (20) @(posedge clk);
    rd(kwd_pkg::OFS_IRQ_STATUS, 32'h0, 32'h0);
    // Expiry without the reset-generator gate does nothing
    wr(kwd_pkg::OFS_CONFIG, cfg(3'h1, 8'hFF, 8'h05, 3'h5));
    kick();
    repeat (40) @(posedge clk);
    check({31'h0, sys_reset_req_o}, 32'h0);
    // Gate open but run clear: still no request
    wr(kwd_pkg::OFS_CONFIG, cfg(3'h1, 8'hFF, 8'h05, 3'h4));
    wr(kwd_pkg::OFS_RG_CONFIG, 32'h2);
    rd(kwd_pkg::OFS_RG_CONFIG, 32'h2, 32'h2);
    kick();
    repeat (40) @(posedge clk);
    check({31'h0, sys_reset_req_o}, 32'h0);
    // Lock forces run and freezes config; kicks keep expiry away meanwhile
    wr(kwd_pkg::OFS_LOCK, 32'h0000003A);
    kick();
    rd(kwd_pkg::OFS_CONFIG, cfg(3'h1, 8'hFF, 8'h05, 3'h5), cfg(3'h1, 8'hFF, 8'h05, 3'h5));
    kick();
    wr(kwd_pkg::OFS_CONFIG, 32'h0);
    kick();
    rd(kwd_pkg::OFS_CONFIG, cfg(3'h1, 8'hFF, 8'h05, 3'h5), cfg(3'h1, 8'hFF, 8'h05, 3'h5));
    for (i = 0; i < 6; i++) begin
      kick();
      repeat (8) @(posedge clk);
    end
    check({31'h0, sys_reset_req_o}, 32'h0);
    // Left alone, the count reaches the expiry value
    repeat (40) @(posedge clk);
    check({31'h0, sys_reset_req_o}, 32'h1);
    rd(kwd_pkg::OFS_RG_STATUS, 32'h40, 32'h40);
    @(posedge clk);
    report_and_stop();
  end
endmodule : kwd_guard_timer_tb
`default_nettype wire
